// [inc/clock_select_defs.svh]
/*
  Register offsets, field positions, reset values and timing counts for the
  clock select block.
  Assumes it is included once per compilation unit by its bare name.
*/
`ifndef CLOCK_SELECT_DEFS_SVH
`define CLOCK_SELECT_DEFS_SVH

// Register byte addresses on the CPU data-memory bus.
`define ADDR_SUB_OSC_MODE 16'hFFF0
`define ADDR_SUBCLOCK_SELECT 16'hFFF2
`define ADDR_PROC_CLOCK_CTRL 16'hFFFB

// Reset values.
`define RST_PROC_CLOCK_CTRL 8'h02
`define RST_SUB_OSC_MODE 8'h00
`define RST_SUBCLOCK_SELECT 8'h00

// Field positions.
`define BIT_MAIN_OSC_DISABLE 7
`define BIT_CPU_DIVIDE_SELECT 1
`define BIT_FEEDBACK_RES_OFF 1
`define BIT_SUB_OSC_STOP 0
`define BIT_CPU_CLOCK_STATUS 5
`define BIT_CPU_SOURCE_SELECT 4

// Main oscillator stabilisation wait after reset, as log2 of its length in main clock periods.
`define STAB_WAIT_LOG2 15
// Old CPU clock ticks kept after a change: 4 for main to main/4, 2 for any other change.
`define HOLD_MAIN_CLKS 4'h4
`define HOLD_SHORT_CLKS 4'h2

`endif

// [inc/clock_select_pkg.sv]
/*
  Types shared by the clock select block.
  Assumes nothing of its surroundings.
*/
package clock_select_pkg;

  // CPU clock choice, one-hot.
  typedef enum logic [2:0] {
    CLK_MAIN_FULL = 3'h1,
    CLK_MAIN_DIV4 = 3'h2,
    CLK_SUB_DIV2 = 3'h4
  } cpu_clk_sel_t;

endpackage : clock_select_pkg

// [rtl/clock_edge_sync.sv]
/*
  Two-flop synchroniser with a rising-edge pulse taken behind it.
  Assumes the input is a slow oscillator level sampled on mclk.
*/
`timescale 1ns/100ps
module clock_edge_sync (
  // Clocking.
  input wire logic mclk,
  input wire logic sysRst,
  input wire logic clkEn,
  // Data.
  input wire logic levelIn,
  output logic risePulse
);

  logic stage1;
  logic stage2;
  logic stage3;

  // The first stage feeds only the second; the edge looks at later stages.
  always_ff @(posedge mclk) begin
    if (sysRst) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else if (clkEn) begin
      stage1 <= levelIn;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  assign risePulse = clkEn & stage2 & ~stage3;

endmodule : clock_edge_sync

// [rtl/dual_osc_clock_select.sv]
/*
  Clock generator control: three byte registers, oscillator enables, CPU
  clock choice between main, main/4 and sub/2, with an edge enable out.
  Assumes each oscillator level holds every phase for one mclk period or
  more, and the CPU bus gives one-cycle write and read strobes with a byte
  address.
*/
`timescale 1ns/100ps
`include "clock_select_defs.svh"

// Notes on behaviour
// - Main oscillator stops on STOP instruction (ignored while on sub/2) or main-oscillator disable bit.
// - Reset loads processor clock control with 02H: main/4, main oscillator on.
// - Processor clock control bit 7 disables the main oscillator when one.
// - Source and divide bits pick main, main/4 or sub/2 CPU clock.
// - Reset clears sub-oscillator mode register to 00H.
// - Sub-oscillator mode bit 1 disconnects the feedback resistor when one.
// - Sub-oscillator mode bit 0 stops the sub oscillator when one.
// - Reset clears subclock select register to 00H, main/4 selected.
// - Subclock select bit 5 reads the clock actually driving the CPU.
// - Subclock select bit 4 chooses main or sub oscillator source.
// - Registers accept whole-byte and single-bit writes.
// - Old CPU clock runs a few more clocks before the switch.
// - Main oscillator held stopped in reset, then 2^15 clocks wait.
module dual_osc_clock_select (
  // Clocking.
  input wire logic mclk,
  input wire logic sysRst,
  input wire logic clkEn,
  // CPU register port.
  input wire logic [15:0] busAddr,
  input wire logic busWrite,
  input wire logic busBitOp,
  input wire logic [2:0] busBitSel,
  input wire logic [7:0] busWdata,
  input wire logic busRead,
  output logic [7:0] busRdata,
  output logic busRdataValid,
  // Oscillator levels and standby request.
  input wire logic mainOscLevel,
  input wire logic subOscLevel,
  input wire logic stopExec,
  // Oscillator controls.
  output logic mainOscEnable,
  output logic subOscEnable,
  output logic feedbackResistorOn,
  // CPU clocking.
  output logic cpuClockEnable,
  output logic cpuRunning
);

  logic mainOscDisable;
  logic cpuDivideSelect;
  logic feedbackResistorOff;
  logic subOscStop;
  logic cpuSourceSelect;
  logic cpuClockStatus;
  logic stopMode;
  logic mainRise;
  logic subRise;
  logic subHalf;
  logic [1:0] mainDiv;
  logic [`STAB_WAIT_LOG2:0] stabCount;
  logic [3:0] holdCount;
  logic [7:0] writeByte;
  logic [7:0] curByte;
  logic tick;
  clock_select_pkg::cpu_clk_sel_t activeSel;
  clock_select_pkg::cpu_clk_sel_t next_sel;

  // Edge pulses of each oscillator, resynchronised to mclk.
  clock_edge_sync mainSync (
    .mclk(mclk), .sysRst(sysRst), .clkEn(clkEn),
    .levelIn(mainOscLevel), .risePulse(mainRise)
  );
  clock_edge_sync subSync (
    .mclk(mclk), .sysRst(sysRst), .clkEn(clkEn),
    .levelIn(subOscLevel), .risePulse(subRise)
  );

  // Current byte for a bit operation, so one bit can change alone.
  always_comb begin
    unique case (busAddr)
      `ADDR_PROC_CLOCK_CTRL: curByte = {mainOscDisable, 5'h00,
                                        cpuDivideSelect, 1'b0};
      `ADDR_SUB_OSC_MODE: curByte = {6'h00, feedbackResistorOff, subOscStop};
      `ADDR_SUBCLOCK_SELECT: curByte = {2'h0, cpuClockStatus,
                                        cpuSourceSelect, 4'h0};
      default: curByte = 8'h00;
    endcase
    writeByte = curByte;
    if (busBitOp) begin
      writeByte[busBitSel] = busWdata[0];
    end else begin
      writeByte = busWdata;
    end
  end

  // Processor clock control: divide select and main disable.
  always_ff @(posedge mclk) begin
    if (sysRst) begin
      mainOscDisable <= 1'(`RST_PROC_CLOCK_CTRL >> `BIT_MAIN_OSC_DISABLE);
      cpuDivideSelect <=
          1'(`RST_PROC_CLOCK_CTRL >> `BIT_CPU_DIVIDE_SELECT);
    end else if (clkEn && busWrite && busAddr == `ADDR_PROC_CLOCK_CTRL) begin
      mainOscDisable <= writeByte[`BIT_MAIN_OSC_DISABLE];
      cpuDivideSelect <= writeByte[`BIT_CPU_DIVIDE_SELECT];
    end
  end

  // Sub-oscillator mode: stop bit and feedback resistor. Other bits unstored.
  always_ff @(posedge mclk) begin
    if (sysRst) begin
      feedbackResistorOff <=
          1'(`RST_SUB_OSC_MODE >> `BIT_FEEDBACK_RES_OFF);
      subOscStop <= 1'(`RST_SUB_OSC_MODE >> `BIT_SUB_OSC_STOP);
    end else if (clkEn && busWrite && busAddr == `ADDR_SUB_OSC_MODE) begin
      feedbackResistorOff <= writeByte[`BIT_FEEDBACK_RES_OFF];
      subOscStop <= writeByte[`BIT_SUB_OSC_STOP];
    end
  end

  // Subclock select: only the source bit is writable; status ignores writes.
  always_ff @(posedge mclk) begin
    if (sysRst) begin
      cpuSourceSelect <=
          1'(`RST_SUBCLOCK_SELECT >> `BIT_CPU_SOURCE_SELECT);
    end else if (clkEn && busWrite && busAddr == `ADDR_SUBCLOCK_SELECT) begin
      cpuSourceSelect <= writeByte[`BIT_CPU_SOURCE_SELECT];
    end
  end

  // STOP holds until reset; wake-up logic lives outside this block.
  always_ff @(posedge mclk) begin
    if (sysRst) begin
      stopMode <= 1'b0;
    end else if (clkEn && stopExec && activeSel != 
                 clock_select_pkg::CLK_SUB_DIV2) begin
      stopMode <= 1'b1;
    end
  end

  // Oscillator enables, registered so outputs come from flops.
  always_ff @(posedge mclk) begin
    if (sysRst) begin
      mainOscEnable <= 1'b0;
      subOscEnable <= 1'b0;
      feedbackResistorOn <= 1'b0;
    end else if (clkEn) begin
      mainOscEnable <= ~mainOscDisable & ~stopMode;
      subOscEnable <= ~subOscStop;
      feedbackResistorOn <= ~feedbackResistorOff;
    end
  end

  // Stabilisation wait counts main oscillator edges after release.
  always_ff @(posedge mclk) begin
    if (sysRst) begin
      stabCount <= '0;
      cpuRunning <= 1'b0;
    end else if (clkEn) begin
      if (!stabCount[`STAB_WAIT_LOG2] && mainRise) begin
        stabCount <= stabCount + 1'b1;
      end
      cpuRunning <= stabCount[`STAB_WAIT_LOG2];
    end
  end

  // Dividers on the oscillator edges.
  always_ff @(posedge mclk) begin
    if (sysRst) begin
      mainDiv <= 2'h0;
      subHalf <= 1'b0;
    end else if (clkEn) begin
      if (mainRise) mainDiv <= mainDiv + 2'h1;
      if (subRise) subHalf <= ~subHalf;
    end
  end

  // Requested selection from the source and divide bits.
  always_comb begin
    if (cpuSourceSelect) begin
      next_sel = clock_select_pkg::CLK_SUB_DIV2;
    end else if (cpuDivideSelect) begin
      next_sel = clock_select_pkg::CLK_MAIN_DIV4;
    end else begin
      next_sel = clock_select_pkg::CLK_MAIN_FULL;
    end
  end

  // CPU tick for the active choice; only whole source periods pass.
  always_comb begin
    unique case (activeSel)
      clock_select_pkg::CLK_MAIN_FULL: tick = mainRise;
      clock_select_pkg::CLK_MAIN_DIV4: tick = mainRise && mainDiv == 2'h3;
      clock_select_pkg::CLK_SUB_DIV2: tick = subRise && subHalf;
      default: tick = 1'b0;
    endcase
  end

  // The switch waits a few old-clock ticks, then changes on a tick boundary,
  // so the old clock's last period is never cut short; the first new tick follows the free-running divider.
  always_ff @(posedge mclk) begin
    if (sysRst) begin
      activeSel <= clock_select_pkg::CLK_MAIN_DIV4;
      holdCount <= 4'h0;
      cpuClockStatus <= 1'(`RST_SUBCLOCK_SELECT >> `BIT_CPU_CLOCK_STATUS);
    end else if (clkEn) begin
      if (next_sel == activeSel) begin
        holdCount <= 4'h0;
      end else if (tick) begin
        if (holdCount + 4'h1 >= ((activeSel == clock_select_pkg::CLK_MAIN_FULL
            && next_sel == clock_select_pkg::CLK_MAIN_DIV4) ?
            `HOLD_MAIN_CLKS : `HOLD_SHORT_CLKS)) begin
          activeSel <= next_sel;
          holdCount <= 4'h0;
        end else begin
          holdCount <= holdCount + 4'h1;
        end
      end
      cpuClockStatus <= (activeSel == clock_select_pkg::CLK_SUB_DIV2);
    end
  end

  // Gated clock enable towards the CPU.
  always_ff @(posedge mclk) begin
    if (sysRst) begin
      cpuClockEnable <= 1'b0;
    end else if (clkEn) begin
      cpuClockEnable <= tick & cpuRunning & ~stopMode;
    end
  end

  // Read port: one cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge mclk) begin
    if (sysRst) begin
      busRdata <= 8'h00;
      busRdataValid <= 1'b0;
    end else if (clkEn) begin
      busRdataValid <= busRead;
      busRdata <= busRead ? curByte : 8'h00;
    end
  end

  a_reset_values: assert property (@(posedge mclk)
    sysRst |=> activeSel == clock_select_pkg::CLK_MAIN_DIV4 &&
    !cpuSourceSelect && cpuDivideSelect && !subOscStop)
    else $error("Reset values wrong.");
  a_main_osc_off: assert property (@(posedge mclk) disable iff (sysRst)
    clkEn && (mainOscDisable || stopMode) |=> !mainOscEnable)
    else $error("Main oscillator not stopped.");
  a_sub_osc_ctl: assert property (@(posedge mclk) disable iff (sysRst)
    clkEn |=> subOscEnable == !$past(subOscStop))
    else $error("Sub oscillator enable wrong.");
  a_feedback_ctl: assert property (@(posedge mclk) disable iff (sysRst)
    clkEn |=> feedbackResistorOn == !$past(feedbackResistorOff))
    else $error("Feedback resistor control wrong.");
  a_status_tracks: assert property (@(posedge mclk) disable iff (sysRst)
    clkEn && $changed(activeSel) |-> ##0 1 ##1
    cpuClockStatus == (activeSel == clock_select_pkg::CLK_SUB_DIV2))
    else $error("Clock status does not follow active clock.");
  a_switch_on_tick: assert property (@(posedge mclk) disable iff (sysRst)
    $changed(activeSel) |-> $past(tick))
    else $error("Clock switched off a tick boundary.");
  a_no_run_early: assert property (@(posedge mclk) disable iff (sysRst)
    !stabCount[`STAB_WAIT_LOG2] |=> !cpuClockEnable)
    else $error("CPU clocked before stabilisation.");
  a_status_ro: assert property (@(posedge mclk) disable iff (sysRst)
    clkEn && busWrite && busAddr == `ADDR_SUBCLOCK_SELECT &&
    activeSel != clock_select_pkg::CLK_SUB_DIV2 |=> !cpuClockStatus)
    else $error("Status bit moved by a write.");
  a_hold_bound: assert property (@(posedge mclk) disable iff (sysRst)
    holdCount <= `HOLD_MAIN_CLKS)
    else $error("Hold count beyond bound.");

  c_to_sub: cover property (@(posedge mclk)
    activeSel == clock_select_pkg::CLK_SUB_DIV2);
  c_to_full: cover property (@(posedge mclk)
    activeSel == clock_select_pkg::CLK_MAIN_FULL);
  c_stop: cover property (@(posedge mclk) stopMode);

endmodule : dual_osc_clock_select

// [verif/osc_model.sv]
/*
  Behavioural main and sub resonators for the clock select block.
  Assumes the enables come from the block and that mclk runs at 8 ns.
*/
`timescale 1ns/100ps
module osc_model (
  // Enables from the block.
  input wire logic mainOscEnable,
  input wire logic subOscEnable,
  // Oscillator levels.
  output logic mainOscLevel,
  output logic subOscLevel
);
  // Main period 16 ns, two mclk periods, toggled on the falling edge, so
  // the long stabilisation wait stays short in simulated time.
  initial begin
    mainOscLevel = 1'b0;
    forever begin
      #8;
      mainOscLevel <= (mainOscEnable === 1'b1) ? ~mainOscLevel : 1'b0;
    end
  end
  // Sub period 96 ns stands in for the slow crystal; stopped means low.
  initial begin
    subOscLevel = 1'b0;
    forever begin
      #48;
      subOscLevel <= (subOscEnable === 1'b1) ? ~subOscLevel : 1'b0;
    end
  end
endmodule : osc_model

// [verif/dual_oscillator_cpu_clock_select_tb.sv]
/*
  Self-checking bench for the clock select block with resonator models.
  Assumes the register port and timing given in the block's hand-over.
*/
`timescale 1ns/100ps
module dual_oscillator_cpu_clock_select_tb;
  logic mclk, sysRst, clkEn, busWrite, busBitOp, busRead, stopExec;
  logic [15:0] busAddr;
  logic [2:0] busBitSel;
  logic [7:0] busWdata, busRdata;
  logic busRdataValid, mainOscLevel, subOscLevel, mainOscEnable;
  logic subOscEnable, feedbackResistorOn, cpuClockEnable, cpuRunning;
  int bad_count = 0;
  int n_tests = 0;

  dual_osc_clock_select dut_u (.mclk(mclk), .sysRst(sysRst), .clkEn(clkEn),
    .busAddr(busAddr), .busWrite(busWrite), .busBitOp(busBitOp),
    .busBitSel(busBitSel), .busWdata(busWdata), .busRead(busRead),
    .busRdata(busRdata), .busRdataValid(busRdataValid),
    .mainOscLevel(mainOscLevel), .subOscLevel(subOscLevel),
    .stopExec(stopExec), .mainOscEnable(mainOscEnable),
    .subOscEnable(subOscEnable), .feedbackResistorOn(feedbackResistorOn),
    .cpuClockEnable(cpuClockEnable), .cpuRunning(cpuRunning));
  osc_model osc_u (.mainOscEnable(mainOscEnable),
    .subOscEnable(subOscEnable), .mainOscLevel(mainOscLevel),
    .subOscLevel(subOscLevel));

  // Free-running 125 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out;
    $display("Checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  // One bus cycle; the strobe drops at the next falling edge.
  task automatic wr(input logic [15:0] a, input logic [7:0] d,
                    input logic bit_op, input logic [2:0] sel);
    @(negedge mclk);
    busAddr = a;
    busWdata = d;
    busBitOp = bit_op;
    busBitSel = sel;
    busWrite = 1'b1;
    @(negedge mclk);
    busWrite = 1'b0;
    busBitOp = 1'b0;
  endtask : wr

  // Read answer is looked at in the one cycle that it stands.
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge mclk);
    busAddr = a;
    busRead = 1'b1;
    @(negedge mclk);
    busRead = 1'b0;
    check({7'h00, busRdataValid}, 8'h01);
    d = busRdata;
  endtask : rd

  // Cycles between two CPU clock pulses, bounded so a dead clock fails.
  task automatic gap(input logic [7:0] exp);
    int n;
    n = 0;
    while (cpuClockEnable !== 1'b1 && n < 250) begin
      @(negedge mclk);
      n++;
    end
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (cpuClockEnable !== 1'b1 && n < 250);
    check(n[7:0], exp);
  endtask : gap

  task automatic wait_cycles(input int n);
    repeat (n) @(negedge mclk);
  endtask : wait_cycles

  // Reset values and reset behaviour of the oscillator controls.
  task automatic t_reset;
    logic [7:0] d;
    @(negedge mclk);
    check({7'h00, mainOscEnable}, 8'h00);
    sysRst = 1'b0;
    wait_cycles(3);
    check({5'h00, mainOscEnable, subOscEnable, feedbackResistorOn}, 8'h07);
    rd(16'hFFFB, d);
    check(d, 8'h02);
    rd(16'hFFF0, d);
    check(d, 8'h00);
    rd(16'hFFF2, d);
    check(d, 8'h00);
    rd(16'hFFF1, d);
    check(d, 8'h00);
  endtask : t_reset

  // Stabilisation wait, then main/4 pacing.
  task automatic t_start;
    int n;
    n = 0;
    while (cpuRunning !== 1'b1 && n < 70000) begin
      @(negedge mclk);
      n++;
    end
    check({7'h00, cpuRunning}, 8'h01);
    check({7'h00, n > 65000}, 8'h01);
    gap(8'h08);
  endtask : t_start

  // Sub oscillator mode bits, by byte and by single bit.
  task automatic t_submode;
    logic [7:0] d;
    wr(16'hFFF0, 8'h03, 1'b0, 3'h0);
    wait_cycles(2);
    check({6'h00, subOscEnable, feedbackResistorOn}, 8'h00);
    rd(16'hFFF0, d);
    check(d, 8'h03);
    wr(16'hFFF0, 8'h00, 1'b1, 3'h0);
    wr(16'hFFF0, 8'h00, 1'b1, 3'h1);
    wait_cycles(2);
    check({6'h00, subOscEnable, feedbackResistorOn}, 8'h03);
  endtask : t_submode

  // Full speed, then sub clock with status, main stop, and back.
  task automatic t_switch;
    logic [7:0] d;
    wr(16'hFFFB, 8'h00, 1'b0, 3'h0);
    wait_cycles(100);
    gap(8'h02);
    wr(16'hFFF2, 8'h10, 1'b0, 3'h0);
    rd(16'hFFF2, d);
    check(d, 8'h10);
    wait_cycles(200);
    rd(16'hFFF2, d);
    check(d, 8'h30);
    gap(8'h18);
    wr(16'hFFF2, 8'h00, 1'b1, 3'h5);
    wr(16'hFFFB, 8'h01, 1'b1, 3'h7);
    wait_cycles(2);
    check({7'h00, mainOscEnable}, 8'h00);
    rd(16'hFFFB, d);
    check(d, 8'h80);
    rd(16'hFFF2, d);
    check(d, 8'h30);
    gap(8'h18);
    wr(16'hFFFB, 8'h00, 1'b0, 3'h0);
    wait_cycles(100);
    wr(16'hFFF2, 8'h00, 1'b0, 3'h0);
    wait_cycles(100);
    rd(16'hFFF2, d);
    check(d, 8'h00);
    wr(16'hFFF2, 8'h01, 1'b1, 3'h5);
    rd(16'hFFF2, d);
    check(d, 8'h00);
    gap(8'h02);
  endtask : t_switch

  // Low clock enable freezes every register, so a write then is lost.
  task automatic t_freeze;
    logic [7:0] d;
    @(negedge mclk);
    clkEn = 1'b0;
    wr(16'hFFF0, 8'h03, 1'b0, 3'h0);
    wait_cycles(2);
    check({6'h00, subOscEnable, feedbackResistorOn}, 8'h03);
    clkEn = 1'b1;
    rd(16'hFFF0, d);
    check(d, 8'h00);
  endtask : t_freeze

  // A STOP instruction halts the main oscillator.
  task automatic t_stop;
    @(negedge mclk);
    stopExec = 1'b1;
    @(negedge mclk);
    stopExec = 1'b0;
    wait_cycles(4);
    check({7'h00, mainOscEnable}, 8'h00);
    check({7'h00, cpuClockEnable}, 8'h00);
  endtask : t_stop

  // Main sequence; clkEn stays high except in the freeze scenario.
  initial begin
    sysRst = 1'b1;
    clkEn = 1'b1;
    busAddr = 16'h0000;
    busWrite = 1'b0;
    busBitOp = 1'b0;
    busBitSel = 3'h0;
    busWdata = 8'h00;
    busRead = 1'b0;
    stopExec = 1'b0;
    repeat (16) @(posedge mclk);
    t_reset();
    t_start();
    t_submode();
    t_switch();
    t_freeze();
    t_stop();
    close_out();
  end

  // The stabilisation wait dominates, about 0.53 ms; allow a third more.
  initial begin
    #700000;
    bad_count++;
    close_out();
  end
endmodule : dual_oscillator_cpu_clock_select_tb
